// [rtl/eprom_ctl_regs.svh]
// register offsets, bit positions, reset values and address windows of the eprom control block
`ifndef EPROM_CTL_REGS_SVH
`define EPROM_CTL_REGS_SVH

`define PROG_CTRL_ADDR      16'h001c
`define TIMEBASE2_ADDR      16'h0011
`define PROG_CTRL_RESET     8'h00
`define TIMEBASE2_RESET     8'h00
`define LATCH_ENABLE_BIT    1
`define PROGRAM_POWER_BIT   0
`define PROG_RSVD_BIT       2
`define PROG_TEST_HI        7
`define PROG_TEST_LO        3
`define WATCHDOG_ENABLE_BIT 1
`define WATCHDOG_CLEAR_BIT  0
`define RAM_BASE            16'h00c0
`define RAM_LAST            16'h01bf
`define RAM_EXEC_ENTRY      16'h00c0
`define EPROM_BASE          16'h1000
`define EPROM_LAST          16'h2fff
`define BOOT_ROM_BASE       16'h3e00
`define BOOT_ROM_LAST       16'h3fef
`define USER_VEC_BASE       16'h3ff0
`define USER_VEC_LAST       16'h3fff
`define ERASED_BYTE         8'hff
`define UNMAPPED_BYTE       8'h00

`endif

// [rtl/eprom_ctl_pkg.sv]
// types shared by the eprom program control and mode select block
package eprom_ctl_pkg;

  typedef enum logic [1:0]
  {
    single_chip_mode = 2'b01,
    bootstrap_mode_e = 2'b10
  } op_mode_t;

  typedef enum logic [5:0]
  {
    reg_none    = 6'b000001,
    reg_ram     = 6'b000010,
    reg_eprom   = 6'b000100,
    reg_boot    = 6'b001000,
    reg_vectors = 6'b010000,
    reg_control = 6'b100000
  } region_t;

  typedef struct packed
  {
    op_mode_t         mode;
    logic             pend_boot;
    logic             armed;
    logic             latch_en;
    logic             power_req;
    logic [4:0]       test_bits;
    logic [5:0]       tb2_bits;
    logic [255:0][7:0] ram;
    logic [7:0]       rdata;
    logic [15:0]      lat_addr;
    logic [7:0]       lat_data;
    logic             lat_strobe;
    logic             boot_out;
    logic             prog_power;
    logic             latch_out;
    logic             wdog_reset;
  } state_t;

endpackage

// [rtl/eprom_mode_ctrl.sv]
// mode latch at reset release, memory decode and eprom programming control
//
// Behaviour
// RQ1: on reset release, latch both mode-select pins and enter the encoded mode.
// RQ2: once entered the mode cannot be changed by software, only by reset.
// RQ3: while reset is low every pin takes its single-chip configuration.
// RQ4: bootstrap only with pin a at test voltage and pin b high.
// RQ5: in bootstrap the reset vector comes from boot ROM 3E00-3FEF.
// RQ6: in bootstrap the boot ROM also supplies the interrupt vectors.
// RQ7: the loader hands control to RAM at 00C0.
// RQ8: bootstrap mode grants access to all privileged control bits.
// RQ9: decode 8K EPROM at 1000-2FFF and 16-byte vectors at 3FF0-3FFF.
// RQ10: provide 256 bytes of internal RAM in the address space.
// RQ11: an erased EPROM location reads as FF.
// RQ12: in user mode only latch enable and program power are writable.
// RQ13: software sets latch, writes data, sets power, waits, clears both.
// RQ14: one write may clear both program power and latch enable.
// RQ15: bits 7-3 read zero in user mode; bit 2 always reads zero.
// RQ16: with latch set, EPROM writes capture address and data; reads unserviced.
// RQ17: with latch clear, EPROM paths are in normal read configuration.
// RQ18: program power reaches the array only while latch enable is set.
// RQ19: program power is forced to zero whenever latch enable is clear.
// RQ20: software should set latch only with programming supply present.
// RQ21: no watchdog; its enable and clear bits at 0011 read zero, no reset.
// RQ22: control register at a chosen address, cleared on any reset.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

module eprom_mode_ctrl
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  input  wire logic        mode_select_pin_a_hv,
  input  wire logic        mode_select_pin_b,
  input  wire logic [15:0] cpu_addr,
  input  wire logic [7:0]  cpu_wdata,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  output logic      [7:0]  cpu_rdata,
  input  wire logic [7:0]  eprom_rdata,
  input  wire logic        eprom_blank,
  input  wire logic [7:0]  boot_rom_rdata,
  output logic             bootstrap_mode,
  output logic             latch_enable,
  output logic             prog_power,
  output logic      [15:0] latched_addr,
  output logic      [7:0]  latched_data,
  output logic             latch_strobe,
  output logic             watchdog_reset
);
  import eprom_ctl_pkg::*;

  `include "eprom_ctl_regs.svh"

  //////////////////////////////////////////////////////////////////////////////

  state_t st;
  state_t next_st;

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic region_t decode(input logic [15:0] a);
    if (a == `PROG_CTRL_ADDR || a == `TIMEBASE2_ADDR)
    begin
      decode = reg_control;
    end
    else if (in_range(a, `RAM_BASE, `RAM_LAST)) // RQ10
    begin
      decode = reg_ram;
    end
    else if (in_range(a, `EPROM_BASE, `EPROM_LAST)) // RQ9
    begin
      decode = reg_eprom;
    end
    else if (in_range(a, `BOOT_ROM_BASE, `BOOT_ROM_LAST)) // RQ5
    begin
      decode = reg_boot;
    end
    else if (in_range(a, `USER_VEC_BASE, `USER_VEC_LAST)) // RQ9
    begin
      decode = reg_vectors;
    end
    else
    begin
      decode = reg_none;
    end
  endfunction

  // the entry point sits on the first ram byte so the loader's jump lands inside ram
  localparam logic [7:0] ram_entry_index = 8'(`RAM_EXEC_ENTRY - `RAM_BASE); // RQ7

  // reset images of the two registers, taken apart into the fields that hold them
  localparam logic [7:0] ctrl_reset_value = `PROG_CTRL_RESET; // RQ22
  localparam logic [7:0] tb2_reset_value  = `TIMEBASE2_RESET;

  region_t    region;
  logic [7:0] ram_index;
  logic       is_boot;
  logic       pins_select_boot;

  assign region           = decode(cpu_addr);
  assign ram_index        = 8'(cpu_addr - `RAM_BASE);
  assign is_boot          = (st.mode == bootstrap_mode_e);
  // ordinary logic levels on pin a never count as the test voltage
  assign pins_select_boot = mode_select_pin_a_hv & mode_select_pin_b; // RQ4

  //////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_st = st;

    if (!reset_n)
    begin
      // all pins stay single-chip until release; the sample taken here is
      // the pin level at the last clock edge while reset is still low
      next_st.mode       = single_chip_mode; // RQ3
      next_st.pend_boot  = pins_select_boot; // RQ1
      next_st.armed      = 1'b1;
      next_st.latch_en   = ctrl_reset_value[`LATCH_ENABLE_BIT]; // RQ22
      next_st.power_req  = ctrl_reset_value[`PROGRAM_POWER_BIT]; // RQ22
      next_st.test_bits  = ctrl_reset_value[`PROG_TEST_HI:`PROG_TEST_LO];
      next_st.tb2_bits   = tb2_reset_value[7:2];
      next_st.rdata      = 8'h00;
      next_st.lat_addr   = 16'h0000;
      next_st.lat_data   = 8'h00;
      next_st.lat_strobe = 1'b0;
      next_st.boot_out   = 1'b0; // RQ3
      next_st.prog_power = 1'b0;
      next_st.latch_out  = 1'b0;
      next_st.wdog_reset = 1'b0;
    end
    else if (clk_en)
    begin
      // the capture strobe lasts one enabled cycle and holds while frozen
      next_st.lat_strobe = 1'b0;

      // mode is taken once per reset; no bus access reaches these fields
      if (st.armed)
      begin
        next_st.mode  = st.pend_boot ? bootstrap_mode_e : single_chip_mode; // RQ1
        next_st.armed = 1'b0; // RQ2
      end

      if (cpu_wr)
      begin
        unique case (region)
          reg_control:
          begin
            if (cpu_addr == `PROG_CTRL_ADDR)
            begin
              next_st.latch_en = cpu_wdata[`LATCH_ENABLE_BIT];
              // power bit cannot stand without the latch bit of the same write
              next_st.power_req = cpu_wdata[`PROGRAM_POWER_BIT]
                                & cpu_wdata[`LATCH_ENABLE_BIT]; // RQ19 RQ14
              if (is_boot) // RQ12
              begin
                next_st.test_bits = cpu_wdata[`PROG_TEST_HI:`PROG_TEST_LO]; // RQ8
              end
              // user mode leaves the test bits untouched
            end
            else
            begin
              next_st.tb2_bits = cpu_wdata[7:2];
            end
          end
          reg_ram:
          begin
            next_st.ram[ram_index] = cpu_wdata;
          end
          reg_eprom, reg_vectors:
          begin
            if (st.latch_en)
            begin
              next_st.lat_addr   = cpu_addr; // RQ16
              next_st.lat_data   = cpu_wdata;
              next_st.lat_strobe = 1'b1;
            end
            // with the latch clear the array is in read mode and ignores writes
          end
          reg_boot, reg_none:
          begin
          end
        endcase
      end

      if (cpu_rd)
      begin
        unique case (region)
          reg_control:
          begin
            if (cpu_addr == `PROG_CTRL_ADDR)
            begin
              next_st.rdata = {is_boot ? st.test_bits : 5'h00, // RQ15 RQ8
                               1'b0, // RQ15
                               st.latch_en, st.power_req};
            end
            else
            begin
              // watchdog enable and clear always read low
              next_st.rdata = {st.tb2_bits, 2'b00}; // RQ21
            end
          end
          reg_ram:
          begin
            next_st.rdata = st.ram[ram_index];
          end
          reg_eprom:
          begin
            if (st.latch_en)
            begin
              next_st.rdata = `ERASED_BYTE; // RQ16
            end
            else
            begin
              next_st.rdata = eprom_blank ? `ERASED_BYTE : eprom_rdata; // RQ17 RQ11
            end
          end
          reg_vectors:
          begin
            if (is_boot)
            begin
              next_st.rdata = boot_rom_rdata; // RQ6 RQ5
            end
            else if (st.latch_en)
            begin
              next_st.rdata = `ERASED_BYTE; // RQ16
            end
            else
            begin
              next_st.rdata = eprom_blank ? `ERASED_BYTE : eprom_rdata; // RQ11
            end
          end
          reg_boot:
          begin
            next_st.rdata = boot_rom_rdata; // RQ5
          end
          reg_none:
          begin
            next_st.rdata = `UNMAPPED_BYTE;
          end
        endcase
      end

      next_st.boot_out   = (next_st.mode == bootstrap_mode_e);
      next_st.latch_out  = next_st.latch_en;
      next_st.prog_power = next_st.power_req & next_st.latch_en; // RQ18
      next_st.wdog_reset = 1'b0; // RQ21
    end
  end

  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  assign cpu_rdata      = st.rdata;
  assign bootstrap_mode = st.boot_out;
  assign latch_enable   = st.latch_out;
  assign prog_power     = st.prog_power;
  assign latched_addr   = st.lat_addr;
  assign latched_data   = st.lat_data;
  assign latch_strobe   = st.lat_strobe;
  assign watchdog_reset = st.wdog_reset;

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk);
  endclocking

  default disable iff (!reset_n);

  power_needs_latch_a: assert property (prog_power |-> latch_enable) // RQ18
    else $error("program power on without latch enable");

  reset_forces_scm_a: assert property (disable iff (1'b0) // RQ3
    !reset_n |=> !bootstrap_mode && !prog_power && !latch_enable)
    else $error("pins not in single-chip state during reset");

  mode_entry_a: assert property ($rose(reset_n) && clk_en |=> // RQ1
    bootstrap_mode == $past(pins_select_boot, 2))
    else $error("mode does not match pins at reset release");

  mode_fixed_a: assert property (!st.armed && !$past(st.armed) |-> // RQ2
    $stable(bootstrap_mode))
    else $error("mode changed without reset");

  ctrl_readback_a: assert property (cpu_rd && clk_en && cpu_addr == `PROG_CTRL_ADDR // RQ15
    |=> cpu_rdata[`PROG_RSVD_BIT] == 1'b0
        && (bootstrap_mode || cpu_rdata[`PROG_TEST_HI:`PROG_TEST_LO] == 5'h00))
    else $error("reserved control bits read nonzero");

  user_bits_locked_a: assert property (cpu_wr && clk_en && !bootstrap_mode // RQ12
    && cpu_addr == `PROG_CTRL_ADDR |=> $stable(st.test_bits))
    else $error("test bits written in user mode");

  clear_both_a: assert property (cpu_wr && clk_en && cpu_addr == `PROG_CTRL_ADDR // RQ14
    && cpu_wdata[1:0] == 2'b00 |=> !latch_enable && !prog_power)
    else $error("single write did not clear latch and power");

  latch_capture_a: assert property (cpu_wr && clk_en && latch_enable // RQ16
    && in_range(cpu_addr, `EPROM_BASE, `EPROM_LAST)
    |=> latch_strobe && latched_addr == $past(cpu_addr) && latched_data == $past(cpu_wdata))
    else $error("eprom write not captured with latch set");

  no_capture_a: assert property (cpu_wr && clk_en && !latch_enable |=> !latch_strobe) // RQ17
    else $error("eprom write captured with latch clear");

  watchdog_zero_a: assert property (cpu_rd && clk_en && cpu_addr == `TIMEBASE2_ADDR // RQ21
    |=> cpu_rdata[1:0] == 2'b00)
    else $error("watchdog bits read nonzero");

  watchdog_quiet_a: assert property (!watchdog_reset) // RQ21
    else $error("watchdog reset seen");

  // reads that go to the array: all eprom bytes, and the vectors outside bootstrap
  logic array_read;

  assign array_read = (region == reg_eprom) || (region == reg_vectors && !is_boot);

  erased_read_a: assert property (cpu_rd && clk_en && array_read // RQ11
    && !latch_enable && eprom_blank
    |=> cpu_rdata == `ERASED_BYTE)
    else $error("erased eprom byte did not read as all ones");

  normal_read_a: assert property (cpu_rd && clk_en && array_read // RQ17
    && !latch_enable && !eprom_blank
    |=> cpu_rdata == $past(eprom_rdata))
    else $error("eprom byte not returned with latch clear");

  latched_read_a: assert property (cpu_rd && clk_en && array_read && latch_enable // RQ16
    |=> cpu_rdata == `ERASED_BYTE)
    else $error("eprom read serviced while latch was set");

  boot_vectors_a: assert property (cpu_rd && clk_en && bootstrap_mode // RQ6
    && region == reg_vectors
    |=> cpu_rdata == $past(boot_rom_rdata))
    else $error("bootstrap vector not taken from boot rom");

  boot_rom_read_a: assert property (cpu_rd && clk_en && region == reg_boot // RQ5
    |=> cpu_rdata == $past(boot_rom_rdata))
    else $error("boot rom byte not returned");

  unmapped_read_a: assert property (cpu_rd && clk_en && region == reg_none // RQ9
    |=> cpu_rdata == `UNMAPPED_BYTE)
    else $error("unmapped read returned nonzero");

  // read data must stand until the next read is taken
  rdata_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata))
    else $error("read data changed without a read");

  // a low enable freezes every registered output, strobe included
  frozen_state_a: assert property (!clk_en |=> $stable(cpu_rdata) && $stable(latch_enable)
    && $stable(prog_power) && $stable(bootstrap_mode) && $stable(latch_strobe)
    && $stable(latched_addr) && $stable(latched_data))
    else $error("state moved while clock enable was low");

  //////////////////////////////////////////////////////////////////////////////

  boot_entry_c: cover property ($rose(reset_n) ##2 bootstrap_mode);
  program_pulse_c: cover property (latch_strobe ##[1:20] prog_power);
  clear_both_c: cover property (prog_power ##1 !latch_enable && !prog_power);
  boot_vector_c: cover property (bootstrap_mode && cpu_rd
    && in_range(cpu_addr, `USER_VEC_BASE, `USER_VEC_LAST));
  ram_entry_c: cover property (cpu_rd && region == reg_ram // RQ7
    && ram_index == ram_entry_index);

endmodule

// [tb/eprom_mem_model.sv]
// eprom array and boot rom contents that face the control block
`timescale 1ns/100ps

module eprom_mem_model
(
  input  wire logic [15:0] cpu_addr,
  output logic      [7:0]  eprom_rdata,
  output logic             eprom_blank,
  output logic      [7:0]  boot_rom_rdata
);
  // bytes ending in ff are erased, so blank and programmed cells sit side by side
  assign eprom_blank = (cpu_addr[7:0] == 8'hff);
  assign eprom_rdata = cpu_addr[7:0] ^ 8'h5a;
  // outside the rom window nothing drives: give a pattern, never a stale byte
  assign boot_rom_rdata = (cpu_addr >= 16'h3e00) ? (cpu_addr[7:0] ^ 8'ha5)
                                                 : ~cpu_addr[7:0];
endmodule

// [tb/eprom_mode_ctrl_bench.sv]
// self-checking bench for the mode latch and eprom program control block
`timescale 1ns/100ps
`include "eprom_ctl_regs.svh"

module eprom_mode_ctrl_bench;
  logic        mclk;
  logic        reset_n;
  logic        clk_en;
  logic        pin_a_hv;
  logic        pin_b;
  logic [15:0] cpu_addr;
  logic [7:0]  cpu_wdata;
  logic        cpu_wr;
  logic        cpu_rd;
  logic [7:0]  cpu_rdata;
  logic [7:0]  eprom_rdata;
  logic        eprom_blank;
  logic [7:0]  boot_rom_rdata;
  logic        bootstrap_mode;
  logic        latch_enable;
  logic        prog_power;
  logic [15:0] latched_addr;
  logic [7:0]  latched_data;
  logic        latch_strobe;
  logic        watchdog_reset;
  logic        strobe_seen;
  int          err_total;
  int          cmp_count;

  ////////////////////////////////////////////////////////////////////////////
  eprom_mode_ctrl u_dut
  (
    .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .mode_select_pin_a_hv(pin_a_hv), .mode_select_pin_b(pin_b),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .eprom_rdata(eprom_rdata), .eprom_blank(eprom_blank),
    .boot_rom_rdata(boot_rom_rdata), .bootstrap_mode(bootstrap_mode),
    .latch_enable(latch_enable), .prog_power(prog_power),
    .latched_addr(latched_addr), .latched_data(latched_data),
    .latch_strobe(latch_strobe), .watchdog_reset(watchdog_reset)
  );

  eprom_mem_model u_mem
  (
    .cpu_addr(cpu_addr), .eprom_rdata(eprom_rdata),
    .eprom_blank(eprom_blank), .boot_rom_rdata(boot_rom_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // a spare edge after each strobe keeps back-to-back calls from double-driving it
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge mclk);
    cpu_wr <= 1'b0;
    #1 strobe_seen = latch_strobe;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge mclk);
    cpu_rd <= 1'b0;
    #1 chk(cpu_rdata, exp);
    @(posedge mclk);
  endtask

  // pins flip after entry so later checks show they no longer matter
  task automatic do_reset(input logic a, input logic b, input logic exp_boot);
    pin_a_hv <= a;
    pin_b    <= b;
    reset_n  <= 1'b0;
    repeat (20) @(posedge mclk);
    #1 chk(bootstrap_mode, 1'b0);
    chk(latch_enable, 1'b0);
    chk(prog_power, 1'b0);
    @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    #1 chk(bootstrap_mode, exp_boot);
    @(posedge mclk);
    pin_a_hv <= ~a;
    pin_b    <= ~b;
    @(posedge mclk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_user_ctrl;
    wr(`PROG_CTRL_ADDR, 8'hff);
    rd(`PROG_CTRL_ADDR, 8'h03);
    wr(`PROG_CTRL_ADDR, 8'h01);
    chk(prog_power, 1'b0);
    rd(16'h1234, 8'h34 ^ 8'h5a);
    rd(16'h12ff, 8'hff);
    rd(16'h3ff0, 8'hf0 ^ 8'h5a);
    wr(16'h1000, 8'h11);
    chk(strobe_seen, 1'b0);
    // the programming supply counts as present while the latch is set
    wr(`PROG_CTRL_ADDR, 8'h02);
    chk(prog_power, 1'b0);
    wr(16'h2fff, 8'h5a);
    chk(strobe_seen, 1'b1);
    chk(latched_addr, 16'h2fff);
    chk(latched_data, 8'h5a);
    rd(16'h2f00, 8'hff);
    wr(`PROG_CTRL_ADDR, 8'h03);
    chk(prog_power, 1'b1);
    repeat (4) @(posedge mclk);
    wr(`PROG_CTRL_ADDR, 8'h00);
    chk({latch_enable, prog_power}, 2'b00);
    chk(bootstrap_mode, 1'b0);
  endtask

  task automatic t_memmap;
    wr(`RAM_EXEC_ENTRY, 8'h3c);
    wr(16'h01bf, 8'hc3);
    rd(16'h00c0, 8'h3c);
    rd(16'h01bf, 8'hc3);
    rd(16'h0500, 8'h00);
    wr(`TIMEBASE2_ADDR, 8'hff);
    rd(`TIMEBASE2_ADDR, 8'hfc);
    chk(watchdog_reset, 1'b0);
    // with the enable low nothing moves: no write lands, the last read byte stands
    clk_en <= 1'b0;
    wr(`PROG_CTRL_ADDR, 8'h02);
    chk(latch_enable, 1'b0);
    rd(16'h00c0, 8'hfc);
    clk_en <= 1'b1;
  endtask

  // leaves latch and power set so the next reset must clear them
  task automatic t_boot;
    wr(`PROG_CTRL_ADDR, 8'hff);
    rd(`PROG_CTRL_ADDR, 8'hfb);
    chk(bootstrap_mode, 1'b1);
    rd(16'h3e00, 8'ha5);
    rd(16'h3ffe, 8'hfe ^ 8'ha5);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #50000;
    err_total++;
    wrap_up;
  end

  initial
  begin
    err_total   = 0;
    cmp_count   = 0;
    reset_n     = 1'b0;
    clk_en      = 1'b1;
    pin_a_hv    = 1'b0;
    pin_b       = 1'b0;
    cpu_addr    = 16'h0000;
    cpu_wdata   = 8'h00;
    cpu_wr      = 1'b0;
    cpu_rd      = 1'b0;
    strobe_seen = 1'b0;
    @(posedge mclk);
    do_reset(1'b0, 1'b0, 1'b0);
    t_user_ctrl;
    t_memmap;
    do_reset(1'b1, 1'b0, 1'b0);
    do_reset(1'b0, 1'b1, 1'b0);
    do_reset(1'b1, 1'b1, 1'b1);
    t_boot;
    do_reset(1'b0, 1'b0, 1'b0);
    wrap_up;
  end
endmodule
